// ---- src/irq_pkg.sv ----
package irq_pkg;
  localparam int NUM_VEC = 32;
  localparam logic [7:0] OFS_PIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_FLAG = 8'h04;
  localparam logic [7:0] OFS_SRC_EN = 8'h08;
  localparam logic [7:0] OFS_CPU_MASK = 8'h0C;
  localparam logic [7:0] OFS_VEC_STAT = 8'h10;
  // Bit positions inside pin_request_status_control; B_MASK is in the CPU mask register.
  localparam int B_PDD = 6;
  localparam int B_EDG = 5;
  localparam int B_PE = 4;
  localparam int B_FLAG = 3;
  localparam int B_ACK = 2;
  localparam int B_IE = 1;
  localparam int B_MOD = 0;
  localparam int B_MASK = 0;
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  localparam logic [31:0] SRC_EN_RST = 32'h0000_0000;
  // Vector numbers of the fixed sources.
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_SWI = 5'h01;
  localparam logic [4:0] VEC_PIN = 5'h02;
  localparam int FIRST_MASKABLE = 2;
  localparam logic [15:0] VEC_TOP = 16'hFFFE;
  localparam int NUM_STACK = 5;
  // Stack order codes: counter low, counter high, X, A, condition codes.
  localparam logic [2:0] STK_PCL = 3'h0;
  localparam logic [2:0] STK_CCR = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STACK = 3'b010,
    ST_FETCH = 3'b100
  } seq_state_t;

  // Address of the high byte of a vector; the low byte follows it.
  function automatic logic [15:0] vec_addr(input logic [4:0] num);
    vec_addr = VEC_TOP - {10'h000, num, 1'b0};
  endfunction
endpackage

// ---- src/irq_core_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface irq_core_if;
  logic pe;
  logic edg;
  logic mode;
  logic ack;
  logic pin;
  logic flag;
  logic asserted;
  logic [31:0] pending;
  logic [4:0] win_num;
  logic win_any;
  modport ctl(output pe, edg, mode, ack, pin, pending,
    input flag, asserted, win_num, win_any);
  modport det(input pe, edg, mode, ack, pin, output flag, asserted);
  modport vec(input pending, output win_num, win_any);
endinterface
`default_nettype wire

// ---- src/pin_event_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect (
  input wire logic pclk,
  input wire logic presetn,
  irq_core_if.det bus
);
  typedef struct packed {
    logic was_asserted;
    logic pe_q;
    logic flag;
  } det_state_t;
  det_state_t st;
  det_state_t next_st;
  logic level_hit;
  logic edge_hit;

  // Polarity 0 means low is asserted, 1 means high is asserted.
  assign bus.asserted = bus.pe & (bus.pin == bus.edg);
  assign edge_hit = bus.asserted & ~st.was_asserted;
  assign level_hit = bus.mode & bus.asserted;
  assign bus.flag = st.flag;

  // Flag update; any set condition beats the acknowledge.
  always_comb begin
    next_st = st;
    next_st.was_asserted = bus.asserted;
    next_st.pe_q = bus.pe;
    if (bus.ack) begin
      next_st.flag = 1'b0;
    end
    if (bus.pe & ~st.pe_q) begin
      next_st.flag = 1'b1;
    end
    if (bus.pe & (edge_hit | level_hit)) begin
      next_st.flag = 1'b1;
    end
    if (~bus.pe) begin
      next_st.flag = st.flag & ~bus.ack;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- src/vector_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module vector_select (
  irq_core_if.vec bus
);
  // Lowest pending vector number wins.
  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // Priority encoder over all slots.
  assign bus.win_num = first_set(bus.pending);
  assign bus.win_any = |bus.pending;
endmodule
`default_nettype wire

// ---- src/ext_irq_controller.sv ----
// Functional notes
// - Pin acts as request input only while pin function enable is 1.
// - Software picks polarity and edge-only or edge-and-level detection.
// - Pin events always set the flag; request only when enabled.
// - Pull device active when enabled and not disabled; up or down.
// - Enabling the pin function sets the pin event flag.
// - Edge-and-level mode keeps flag set while pin stays asserted.
// - Clocked logic detects events; an async path wakes from stop.
// - Pin level feeds branch-if-high and branch-if-low when enabled.
// - Vector is two bytes, high byte at the lower address.
// - Source flags set on events; forwarded only with local enable.
// - Unmasked request: stack PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, CONDITION_CODE_REGISTER, mask, fetch.
// - 32 slots from FFC0 to FFFE; vector 0 highest priority.
// - All reset causes share vector 0.
// - Writing 1 to acknowledge clears the flag; reads give 0.
// - Polarity 0 falling or low; 1 rising or high.
// - With interrupt enable set, flag raises request; else poll.
// - Global mask set by reset until software clears it.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_controller #(
  parameter int NUM_SRC = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pin,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [4:0] reset_cause,
  input wire logic swi_exec,
  input wire logic cpu_boundary,
  input wire logic stop_mode,
  output logic pull_enable,
  output logic pull_up,
  output logic stop_wake,
  output logic branch_if_pin_high,
  output logic branch_if_pin_low,
  output logic cpu_irq_req,
  output logic stack_valid,
  output logic [2:0] stack_sel,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic [4:0] fetch_vec
);
  typedef struct packed {
    logic pdd;
    logic edg;
    logic pe;
    logic ie;
    logic mode;
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] src_en;
    logic mask;
    logic swi_pend;
    irq_pkg::seq_state_t seq;
    logic [2:0] step;
    logic fetch_lo;
    logic [4:0] vec;
    logic [15:0] addr;
    logic [31:0] rdata;
  } ctl_state_t;
  ctl_state_t st;
  ctl_state_t next_st;
  irq_core_if core();
  logic wr;
  logic setup;
  logic hit;
  logic [31:0] pend;
  logic [31:0] maskable;
  logic [31:0] wmask;
  logic [7:0] ctrl_rd;

  pin_event_detect u_det (
    .pclk(pclk),
    .presetn(presetn),
    .bus(core)
  );

  vector_select u_vec (
    .bus(core)
  );

  // Control fields fed to the detector.
  assign core.pe = st.pe;
  assign core.edg = st.edg;
  assign core.mode = st.mode;
  assign core.pin = irq_pin;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign core.ack = wr & (paddr == irq_pkg::OFS_PIN_CTRL)
    & pwdata[irq_pkg::B_ACK];

  // Pending map: resets, software interrupt, pin, then peripherals.
  always_comb begin
    pend = '0;
    pend[NUM_SRC-1:0] = st.src_flag & st.src_en;
    pend[irq_pkg::VEC_PIN] = core.flag & st.ie;
    pend[irq_pkg::VEC_SWI] = st.swi_pend;
    pend[irq_pkg::VEC_RESET] = |reset_cause;
  end
  assign maskable = pend
    & ~((32'h0000_0001 << irq_pkg::FIRST_MASKABLE) - 32'h0000_0001);
  assign core.pending = pend;

  // Request to the core; only slots above the software one are masked.
  assign cpu_irq_req = (|pend[irq_pkg::VEC_SWI:irq_pkg::VEC_RESET])
    | ((|maskable) & ~st.mask);

  // Pull device and pin level paths.
  assign pull_enable = st.pe & ~st.pdd;
  assign pull_up = ~st.edg;
  assign branch_if_pin_high = st.pe & irq_pin;
  assign branch_if_pin_low = st.pe & ~irq_pin;
  // Unclocked wake path for stop mode when clocks are off.
  assign stop_wake = stop_mode & core.asserted;

  // Sequencer outputs.
  assign stack_valid = st.seq == irq_pkg::ST_STACK;
  assign stack_sel = st.step;
  assign fetch_valid = st.seq == irq_pkg::ST_FETCH;
  assign fetch_addr = st.addr;
  assign fetch_vec = st.vec;

  // Bus answers: no wait states, error on unmapped offsets.
  always_comb begin
    hit = (paddr == irq_pkg::OFS_PIN_CTRL) | (paddr == irq_pkg::OFS_SRC_FLAG)
      | (paddr == irq_pkg::OFS_SRC_EN) | (paddr == irq_pkg::OFS_CPU_MASK)
      | (paddr == irq_pkg::OFS_VEC_STAT);
  end
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign prdata = st.rdata;

  // Control register read image; acknowledge bit always reads 0.
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[irq_pkg::B_PDD] = st.pdd;
    ctrl_rd[irq_pkg::B_EDG] = st.edg;
    ctrl_rd[irq_pkg::B_PE] = st.pe;
    ctrl_rd[irq_pkg::B_FLAG] = core.flag;
    ctrl_rd[irq_pkg::B_IE] = st.ie;
    ctrl_rd[irq_pkg::B_MOD] = st.mode;
  end

  // Register writes, flag capture, read capture and interrupt sequence.
  always_comb begin
    next_st = st;
    wmask = '0;
    if (wr) begin
      if (paddr == irq_pkg::OFS_PIN_CTRL) begin
        next_st.pdd = pwdata[irq_pkg::B_PDD];
        next_st.edg = pwdata[irq_pkg::B_EDG];
        next_st.pe = pwdata[irq_pkg::B_PE];
        next_st.ie = pwdata[irq_pkg::B_IE];
        next_st.mode = pwdata[irq_pkg::B_MOD];
      end else if (paddr == irq_pkg::OFS_SRC_FLAG) begin
        wmask = pwdata;
      end else if (paddr == irq_pkg::OFS_SRC_EN) begin
        next_st.src_en = pwdata[NUM_SRC-1:0];
      end else if (paddr == irq_pkg::OFS_CPU_MASK) begin
        next_st.mask = pwdata[irq_pkg::B_MASK];
      end
    end
    // Write one to clear; a same-cycle event keeps its flag.
    next_st.src_flag = (st.src_flag & ~wmask[NUM_SRC-1:0])
      | src_event;
    if (swi_exec) begin
      next_st.swi_pend = 1'b1;
    end
    if (setup) begin
      if (paddr == irq_pkg::OFS_PIN_CTRL) begin
        next_st.rdata = {24'h000000, ctrl_rd};
      end else if (paddr == irq_pkg::OFS_SRC_FLAG) begin
        next_st.rdata = 32'(st.src_flag);
      end else if (paddr == irq_pkg::OFS_SRC_EN) begin
        next_st.rdata = 32'(st.src_en);
      end else if (paddr == irq_pkg::OFS_CPU_MASK) begin
        next_st.rdata = {31'h00000000, st.mask};
      end else if (paddr == irq_pkg::OFS_VEC_STAT) begin
        next_st.rdata = {irq_pkg::vec_addr(core.win_num), 7'h00,
          core.win_any, 3'h0, core.win_num};
      end else begin
        next_st.rdata = '0;
      end
    end
    case (st.seq)
      irq_pkg::ST_IDLE: begin
        // Take the request only at an instruction boundary.
        if (cpu_boundary & cpu_irq_req) begin
          next_st.seq = irq_pkg::ST_STACK;
          next_st.step = irq_pkg::STK_PCL;
        end
      end
      irq_pkg::ST_STACK: begin
        next_st.step = st.step + 3'h1;
        if (st.step == irq_pkg::STK_CCR) begin
          next_st.mask = 1'b1;
          next_st.seq = irq_pkg::ST_FETCH;
          next_st.fetch_lo = 1'b0;
          next_st.vec = core.win_num;
          next_st.addr = irq_pkg::vec_addr(core.win_num);
        end
      end
      irq_pkg::ST_FETCH: begin
        // High byte first, then the next higher address.
        next_st.fetch_lo = 1'b1;
        next_st.addr = st.addr + 16'h0001;
        if (st.fetch_lo) begin
          next_st.seq = irq_pkg::ST_IDLE;
          if (st.vec == irq_pkg::VEC_SWI) begin
            next_st.swi_pend = swi_exec;
          end
        end
      end
      default: begin
        next_st.seq = irq_pkg::ST_IDLE;
      end
    endcase
  end

  // State register; the global mask comes out of reset set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mask <= 1'b1;
      st.src_en <= irq_pkg::SRC_EN_RST[NUM_SRC-1:0];
      st.seq <= irq_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- sim/ext_irq_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_irq_chk (
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic irq_pin, cpu_boundary, stop_mode, pull_enable, pull_up,
  input wire logic stop_wake, branch_if_pin_high, branch_if_pin_low,
  input wire logic cpu_irq_req, stack_valid, fetch_valid,
  input wire logic [4:0] reset_cause, fetch_vec,
  input wire logic [2:0] stack_sel,
  input wire logic [15:0] fetch_addr
);
  logic [6:0] c;
  // The shadow c holds the pin control bits of the last completed write.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c <= 7'h00;
    else if (psel && penable && pwrite && paddr == 8'h00) c <= pwdata[6:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin outputs follow the shadowed control bits and the pin level.
  a_pull_dev: assert property (
    pull_enable == (c[4] & !c[6]) && pull_up == !c[5]) else $error("pull");
  a_branch_lvl: assert property (
    branch_if_pin_high == (c[4] & irq_pin) &&
    branch_if_pin_low == (c[4] & !irq_pin)) else $error("branch");
  a_wake_path: assert property (
    stop_wake == (stop_mode & c[4] & (irq_pin == c[5]))) else $error("wake");
  a_stack_order: assert property (
    $rose(stack_valid) |-> stack_sel == 3'h0 ##1 stack_sel == 3'h1 ##1
    stack_sel == 3'h2 ##1 stack_sel == 3'h3 ##1 stack_sel == 3'h4 ##1
    fetch_valid && !stack_valid) else $error("stack order");
  a_seq_start: assert property (
    !stack_valid && !fetch_valid && cpu_boundary && cpu_irq_req
    |=> stack_valid) else $error("no sequence start");
  a_vec_addr: assert property (
    $rose(fetch_valid) |-> fetch_addr == 16'hFFFE - {10'h000, fetch_vec, 1'h0})
    else $error("vector address");
  a_vec_pair: assert property (
    $rose(fetch_valid) |=> fetch_valid && fetch_addr == $past(fetch_addr) +
    16'h0001) else $error("vector low byte");
  a_reset_req: assert property (|reset_cause |-> cpu_irq_req)
    else $error("reset request");
endmodule
bind ext_irq_controller ext_irq_chk u_ext_irq_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .irq_pin, .cpu_boundary, .stop_mode,
  .pull_enable, .pull_up, .stop_wake, .branch_if_pin_high, .branch_if_pin_low,
  .cpu_irq_req, .stack_valid, .fetch_valid, .reset_cause, .fetch_vec,
  .stack_sel, .fetch_addr);
`default_nettype wire

// ---- sim/irq_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_source (
  input wire logic pclk, drive_en, drive_val, pull_enable, pull_up,
  output logic pin
);
  logic last;
  // A floating, unpulled line shows the inverse of its last level.
  always_ff @(posedge pclk) last <= pin;
  // The source drives the line, else the pull device holds it while pull_enable is set.
  always_comb pin = drive_en ? drive_val : (pull_enable ? pull_up : !last);
endmodule
`default_nettype wire

// ---- sim/tb_ext_irq_pin_and_vector_priority.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ext_irq_pin_and_vector_priority;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pin, rerr;
  logic swi_exec, cpu_boundary, stop_mode, pull_enable, pull_up, stop_wake;
  logic branch_if_pin_high, branch_if_pin_low, cpu_irq_req, stack_valid;
  logic fetch_valid, drv_en, drv_val;
  logic [31:0] pwdata, prdata, src_event, rdat;
  logic [15:0] fetch_addr;
  logic [7:0] paddr;
  logic [4:0] reset_cause, fetch_vec;
  logic [2:0] stack_sel;
  int mismatches = 0;
  int total_checks = 0;
  ext_irq_controller u_ext_irq_controller (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_pin,
    .src_event, .reset_cause, .swi_exec, .cpu_boundary, .stop_mode,
    .pull_enable, .pull_up, .stop_wake, .branch_if_pin_high,
    .branch_if_pin_low, .cpu_irq_req, .stack_valid, .stack_sel,
    .fetch_valid, .fetch_addr, .fetch_vec);
  irq_source u_irq_source (.pclk, .drive_en(drv_en), .drive_val(drv_val),
    .pull_enable, .pull_up, .pin(irq_pin));
  // Bus clock with a 4 ns period.
  always #2 pclk = !pclk;
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    mismatches += int'(got !== exp);
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  // An APB transfer is held until pready is seen at a rising edge.
  task automatic xfer(input logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, logic [31:0] m, e);
    xfer(1'h0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic pin(input logic v);
    drv_val <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_edge();
    rd(8'h00, 32'hFF, 32'h00);
    rd(8'h0C, 32'h01, 32'h01);
    rd(8'h20, 32'hFFFF_FFFF, 32'h0);
    chk(rerr, 1'h1);
    xfer(1'h1, 8'h00, 32'h10);
    rd(8'h00, 32'h0C, 32'h08);
    chk({pull_enable, pull_up}, 2'h3);
    xfer(1'h1, 8'h00, 32'h14);
    rd(8'h00, 32'h0C, 32'h00);
    pin(1'h0);
    rd(8'h00, 32'h08, 32'h08);
    chk(cpu_irq_req, 1'h0);
    xfer(1'h1, 8'h00, 32'h14);
    pin(1'h1);
    rd(8'h00, 32'h08, 32'h00);
  endtask
  task automatic t_level();
    xfer(1'h1, 8'h00, 32'h35);
    xfer(1'h1, 8'h00, 32'h35);
    rd(8'h00, 32'h08, 32'h08);
    chk(pull_up, 1'h0);
    pin(1'h0);
    xfer(1'h1, 8'h00, 32'h35);
    rd(8'h00, 32'h08, 32'h00);
  endtask
  task automatic t_off();
    xfer(1'h1, 8'h00, 32'h24);
    stop_mode <= 1'h1;
    pin(1'h1);
    chk({stop_wake, branch_if_pin_high}, 2'h0);
    rd(8'h00, 32'h08, 32'h00);
    xfer(1'h1, 8'h00, 32'h30);
    @(negedge pclk);
    chk({stop_wake, branch_if_pin_high}, 2'h3);
  endtask
  task automatic t_seq();
    xfer(1'h1, 8'h00, 32'h14);
    repeat (6) @(posedge pclk);
    xfer(1'h1, 8'h00, 32'h13);
    pin(1'h0);
    xfer(1'h1, 8'h0C, 32'h00);
    @(negedge pclk);
    chk(cpu_irq_req, 1'h1);
    @(posedge pclk);
    cpu_boundary <= 1'h1;
    @(posedge pclk);
    cpu_boundary <= 1'h0;
    do @(negedge pclk); while (fetch_valid !== 1'h1);
    chk({fetch_vec, fetch_addr}, {5'h02, 16'hFFFA});
    @(negedge pclk);
    chk({cpu_irq_req, fetch_addr}, {1'h0, 16'hFFFB});
    @(posedge pclk);
    pin(1'h1);
    xfer(1'h1, 8'h00, 32'h16);
  endtask
  task automatic t_prio();
    xfer(1'h1, 8'h08, 32'h0010_0020);
    src_event <= 32'h0010_0028;
    @(posedge pclk);
    src_event <= 32'h0;
    rd(8'h10, 32'hFFFF_01FF, 32'hFFF4_0105);
    reset_cause <= 5'h04;
    rd(8'h10, 32'hFFFF_01FF, 32'hFFFE_0100);
    chk(cpu_irq_req, 1'h1);
    reset_cause <= 5'h00;
  endtask
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hold reset for twelve cycles, then run every scenario in turn.
  initial begin
    {pclk, presetn, psel, penable, pwrite, swi_exec} = 6'h00;
    {cpu_boundary, stop_mode, drv_en, drv_val} = 4'h3;
    {paddr, pwdata, src_event, reset_cause} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_edge();
    t_level();
    t_off();
    t_seq();
    t_prio();
    final_report();
  end
  // A hung wait is cut short long after the scenarios should be done.
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
